// file: rtl/duc_top.sv
// Update, clear, busy and output-control logic of the 40-channel converter
`timescale 1ns/10ps
`include "duc_params.svh"
module duc_top import duc_pkg::*; #(
	parameter int NCH = 40,
	parameter int DW = 14,
	parameter int RESET_SEQ_CYC = `DUC_RESET_SEQ_CYC
) (
	// Clock and system reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Device pins
	input wire logic dev_reset_n_i,
	input wire logic output_clear_n_i,
	input wire logic load_strobe_n_i,
	input wire logic temp_over_i,
	// Shared busy line
	input wire logic busy_n_i,
	output logic busy_n_o,
	output logic busy_n_oe_o,
	// Channel outputs
	output logic [NCH*DW-1:0] out_code_o,
	output logic out_connect_o,
	output logic converter_on_o
);
	localparam int NGRP = NCH / 8;
	localparam int CW = $clog2(NCH);
	localparam logic [4:0] STAGE_LAST = 5'(`DUC_STAGE_CYC - 1);
	// Tail gives back the cycle that takes the write and the cycle that drops the pin,
	// so the whole busy drive stays within (channels plus one) stages plus the tail
	localparam logic [4:0] TAIL_LAST = 5'(`DUC_STAGE_CYC + `DUC_TAIL_CYC - 3);
	localparam logic [4:0] AB_LAST = 5'(`DUC_AB_BUSY_CYC - 1);

	// Computes one output code from input, gain and offset, clamped to range
	function automatic logic [DW-1:0] calc(input logic [DW-1:0] x, input logic [DW-1:0] m,
		input logic [DW-1:0] c);
		logic [2*DW:0] prod;
		logic [16:0] sum;
		prod = {1'b0, x} * ({1'b0, m} + 15'h0001);
		sum = 17'(prod[2*DW:DW]) + 17'(c);
		if (sum < `DUC_CODE_MID) begin
			calc = '0;
		end else if (sum - `DUC_CODE_MID > `DUC_CODE_MAX) begin
			calc = DW'(`DUC_CODE_MAX);
		end else begin
			calc = DW'(sum - `DUC_CODE_MID);
		end
	endfunction

	// Lowest set bit of a channel mask
	function automatic logic [CW-1:0] first_set(input logic [NCH-1:0] v);
		first_set = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = CW'(i);
			end
		end
	endfunction

	// Channels touched by one command
	function automatic logic [NCH-1:0] span_mask(input duc_span_t span, input logic [5:0] adr);
		span_mask = '0;
		for (int i = 0; i < NCH; i++) begin
			unique case (span)
				DUC_SPAN_ONE: span_mask[i] = (6'(i) == adr);
				DUC_SPAN_GROUP: span_mask[i] = (3'(i / 8) == adr[5:3]);
				DUC_SPAN_SAME_CH: span_mask[i] = (3'(i % 8) == adr[2:0]);
				DUC_SPAN_ALL: span_mask[i] = 1'b1;
			endcase
		end
	endfunction

	logic [DW-1:0] in_a [NCH];
	logic [DW-1:0] in_b [NCH];
	logic [DW-1:0] gain [NCH];
	logic [DW-1:0] offs [NCH];
	logic [DW-1:0] comp_a [NCH];
	logic [DW-1:0] comp_b [NCH];
	logic [NCH-1:0] ab_sel;
	logic [NCH-1:0] pend_a;
	logic [NCH-1:0] pend_b;
	logic [NCH-1:0] dirty;
	logic power_down;
	logic therm_en;
	logic ab_bit;
	logic therm_flag;
	logic [CW-1:0] ch_index;
	logic reset_pin_q;
	logic seq_active;
	logic [13:0] seq_cnt;
	logic hold_after_reset;
	logic hold_clear;
	logic load_pending;
	logic load_q;
	logic [4:0] ab_cnt;
	duc_eng_t eng_state;
	logic [4:0] eng_cnt;
	logic [CW-1:0] eng_ch;
	logic calc_done;
	logic [CW-1:0] calc_ch;

	logic wb_fire;
	logic wr_ok;
	logic cmd_wr;
	logic ab_wr;
	logic [2:0] ab_grp;
	duc_mode_t cmd_mode;
	logic [NCH-1:0] cmd_mask;
	logic [DW-1:0] cmd_data;
	logic in_defaults;
	logic own_busy;
	logic load_fire;
	logic [NCH-1:0] next_pend_a;
	logic [NCH-1:0] next_pend_b;
	logic [NCH-1:0] ab_new;

	assign wb_fire = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Defaults held through the reset pin and the restore sequence
	assign in_defaults = !dev_reset_n_i || seq_active;
	// Host writes during the restore sequence are dropped
	assign wr_ok = wb_fire && wb_we_i && !in_defaults;
	assign cmd_wr = wr_ok && wb_adr_i == `DUC_ADR_COMMAND && wb_sel_i == 4'hf;
	assign ab_grp = 3'((wb_adr_i - `DUC_ADR_AB_SEL0) >> 2);
	assign ab_wr = wr_ok && wb_sel_i[0] && wb_adr_i >= `DUC_ADR_AB_SEL0 && wb_adr_i[1:0] == 2'b00
		&& 32'(ab_grp) < NGRP && wb_adr_i < `DUC_ADR_STATUS;
	assign cmd_mode = duc_mode_t'(wb_dat_i[`DUC_CMD_MODE_LSB +: 2]);
	assign cmd_mask = span_mask(duc_span_t'(wb_dat_i[`DUC_CMD_SPAN_LSB +: 2]),
		wb_dat_i[`DUC_CMD_ADDR_LSB +: 6]);
	assign cmd_data = wb_dat_i[`DUC_CMD_DATA_LSB +: DW];
	assign own_busy = eng_state != DUC_ENG_IDLE || ab_cnt != 5'h00 || pend_a != '0 || pend_b != '0;
	// Load only when the shared line is released by every device
	// Strobes are ignored while clear is low
	assign load_fire = !in_defaults && busy_n_i && !busy_n_oe_o && output_clear_n_i
		&& (load_pending || !load_strobe_n_i);

	always_comb begin
		next_pend_a = pend_a;
		next_pend_b = pend_b;
		if (eng_state == DUC_ENG_CALC && eng_cnt == 5'h00) begin
			if (pend_a[eng_ch]) begin
				next_pend_a[eng_ch] = 1'b0;
			end else begin
				next_pend_b[eng_ch] = 1'b0;
			end
		end
		// New writes win over the engine retiring the same channel
		if (cmd_wr && cmd_mode != DUC_MODE_SPECIAL) begin
			if (ab_bit) begin
				next_pend_b = next_pend_b | cmd_mask;
			end else begin
				next_pend_a = next_pend_a | cmd_mask;
			end
		end
	end

	always_comb begin
		ab_new = ab_sel;
		if (ab_wr) begin
			ab_new[ab_grp*8 +: 8] = wb_dat_i[7:0];
		end
	end

	// Wishbone answer: ack one cycle after the strobe, unmapped reads return zero except unaligned select offsets, which read their group
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_fire;
			wb_dat_o <= '0;
			if (wb_fire && !wb_we_i) begin
				if (wb_adr_i == `DUC_ADR_CONTROL) begin
					wb_dat_o[`DUC_CTL_POWER_DOWN] <= power_down;
					wb_dat_o[`DUC_CTL_THERM_EN] <= therm_en;
					wb_dat_o[`DUC_CTL_AB_BIT] <= ab_bit;
					wb_dat_o[`DUC_CTL_THERM_FLAG] <= therm_flag;
				end else if (wb_adr_i == `DUC_ADR_STATUS) begin
					wb_dat_o[5:0] <= {hold_after_reset, hold_clear, load_pending, seq_active,
						!busy_n_i, busy_n_oe_o};
				end else if (wb_adr_i == `DUC_ADR_CH_INDEX) begin
					wb_dat_o[CW-1:0] <= ch_index;
				end else if (wb_adr_i == `DUC_ADR_CH_DATA) begin
					wb_dat_o[DW-1:0] <= out_code_o[ch_index*DW +: DW];
				end else if (wb_adr_i >= `DUC_ADR_AB_SEL0 && wb_adr_i < `DUC_ADR_STATUS
					&& 32'(ab_grp) < NGRP) begin
					wb_dat_o[7:0] <= ab_sel[ab_grp*8 +: 8];
				end
			end
		end
	end

	// Control register and thermal latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_down <= 1'b0;
			therm_en <= 1'b0;
			ab_bit <= 1'b0;
			therm_flag <= 1'b0;
			ch_index <= '0;
		end else begin
			if (wr_ok && wb_sel_i[0] && wb_adr_i == `DUC_ADR_CONTROL) begin
				power_down <= wb_dat_i[`DUC_CTL_POWER_DOWN];
				therm_en <= wb_dat_i[`DUC_CTL_THERM_EN];
				ab_bit <= wb_dat_i[`DUC_CTL_AB_BIT];
			end
			if (wr_ok && wb_sel_i[0] && wb_adr_i == `DUC_ADR_CH_INDEX) begin
				ch_index <= (32'(wb_dat_i[CW-1:0]) < NCH) ? wb_dat_i[CW-1:0] : ch_index;
			end
			// Latched while enabled; only clearing the enable releases it
			if (!therm_en) begin
				therm_flag <= 1'b0;
			end else if (temp_over_i) begin
				therm_flag <= 1'b1;
			end
			if (wr_ok && wb_sel_i[0] && wb_adr_i == `DUC_ADR_CONTROL && !wb_dat_i[`DUC_CTL_THERM_EN]) begin
				therm_flag <= 1'b0;
			end
		end
	end

	// Restore sequence started by the release of the reset pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_pin_q <= 1'b1;
			seq_active <= 1'b0;
			seq_cnt <= '0;
		end else begin
			reset_pin_q <= dev_reset_n_i;
			if (dev_reset_n_i && !reset_pin_q) begin
				seq_active <= 1'b1;
				seq_cnt <= 14'(RESET_SEQ_CYC - 1);
			end else if (seq_active) begin
				seq_cnt <= seq_cnt - 14'h0001;
				seq_active <= seq_cnt != 14'h0000;
			end
		end
	end

	// Input, gain and offset storage; defaults restored by the sequence
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NCH; i++) begin
			if (rst_i || in_defaults) begin
				in_a[i] <= `DUC_DEF_INPUT;
				in_b[i] <= `DUC_DEF_INPUT;
				gain[i] <= `DUC_DEF_GAIN;
				offs[i] <= `DUC_DEF_OFFSET;
			end else if (cmd_wr && cmd_mask[i]) begin
				// Accepted even while the engine is busy
				unique case (cmd_mode)
					DUC_MODE_INPUT: begin
						if (ab_bit) begin
							in_b[i] <= cmd_data;
						end else begin
							in_a[i] <= cmd_data;
						end
					end
					DUC_MODE_OFFSET: offs[i] <= cmd_data;
					DUC_MODE_GAIN: gain[i] <= cmd_data;
					DUC_MODE_SPECIAL: begin
					end
				endcase
			end
		end
	end

	// Shared calculation engine: one channel per stage, then a closing tail
	always_ff @(posedge clk_i) begin
		if (rst_i || in_defaults) begin
			eng_state <= DUC_ENG_IDLE;
			eng_cnt <= '0;
			eng_ch <= '0;
			pend_a <= '0;
			pend_b <= '0;
			calc_done <= 1'b0;
			calc_ch <= '0;
			for (int i = 0; i < NCH; i++) begin
				comp_a[i] <= `DUC_DEF_INPUT;
				comp_b[i] <= `DUC_DEF_INPUT;
			end
		end else begin
			pend_a <= next_pend_a;
			pend_b <= next_pend_b;
			calc_done <= 1'b0;
			unique case (eng_state)
				DUC_ENG_IDLE: begin
					if (pend_a != '0 || pend_b != '0) begin
						eng_state <= DUC_ENG_CALC;
						eng_cnt <= STAGE_LAST;
						eng_ch <= first_set(pend_a | pend_b);
					end
				end
				DUC_ENG_CALC: begin
					if (eng_cnt != 5'h00) begin
						eng_cnt <= eng_cnt - 5'h01;
					end else begin
						// Channels are worked off one at a time
						if (pend_a[eng_ch]) begin
							comp_a[eng_ch] <= calc(in_a[eng_ch], gain[eng_ch], offs[eng_ch]);
						end else begin
							comp_b[eng_ch] <= calc(in_b[eng_ch], gain[eng_ch], offs[eng_ch]);
						end
						calc_done <= 1'b1;
						calc_ch <= eng_ch;
						// Stage per channel plus tail keeps busy within bound
						if (next_pend_a != '0 || next_pend_b != '0) begin
							eng_cnt <= STAGE_LAST;
							eng_ch <= first_set(next_pend_a | next_pend_b);
						end else begin
							eng_state <= DUC_ENG_TAIL;
							eng_cnt <= TAIL_LAST;
						end
					end
				end
				DUC_ENG_TAIL: begin
					eng_cnt <= eng_cnt - 5'h01;
					if (eng_cnt == 5'h00) begin
						eng_state <= DUC_ENG_IDLE;
					end
				end
			endcase
		end
	end

	// A/B select registers and their short busy pulse
	always_ff @(posedge clk_i) begin
		if (rst_i || in_defaults) begin
			ab_sel <= '0;
			ab_cnt <= '0;
		end else begin
			// Toggle changes the source only, no recalculation
			ab_sel <= ab_new;
			if (ab_wr) begin
				ab_cnt <= AB_LAST + 5'h01;
			end else if (ab_cnt != 5'h00) begin
				ab_cnt <= ab_cnt - 5'h01;
			end
		end
	end

	// Busy pin: only ever pulled low, driven while any work is outstanding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_n_o <= 1'b0;
			busy_n_oe_o <= 1'b0;
		end else begin
			busy_n_o <= 1'b0;
			busy_n_oe_o <= !in_defaults && (own_busy || cmd_wr || ab_wr);
		end
	end

	// Load strobe capture; a falling edge while busy is kept for later
	always_ff @(posedge clk_i) begin
		if (rst_i || in_defaults) begin
			load_q <= 1'b1;
			load_pending <= 1'b0;
		end else begin
			load_q <= load_strobe_n_i;
			if (load_fire) begin
				load_pending <= 1'b0;
			end else if (load_q && !load_strobe_n_i && output_clear_n_i) begin
				load_pending <= 1'b1;
			end
		end
	end

	// Channels changed since the last load; new changes win over the load clearing them
	always_ff @(posedge clk_i) begin
		if (rst_i || in_defaults) begin
			dirty <= '0;
		end else begin
			dirty <= (dirty & ~(load_fire ? dirty : '0)) | (ab_new ^ ab_sel)
				| (calc_done ? (NCH'(1) << calc_ch) : '0);
		end
	end

	// Channel output registers; a held-low strobe fires whenever busy releases while clear is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_code_o <= '0;
		end else if (load_fire) begin
			for (int i = 0; i < NCH; i++) begin
				// Unchanged channels keep their value
				if (dirty[i]) begin
					out_code_o[i*DW +: DW] <= ab_sel[i] ? comp_b[i] : comp_a[i];
				end
			end
			// Source chosen per channel by its select bit
		end
	end

	// Output hold flags after reset and after clear
	always_ff @(posedge clk_i) begin
		if (rst_i || in_defaults) begin
			hold_after_reset <= 1'b1;
			hold_clear <= !output_clear_n_i;
		end else begin
			// Released only by a load that carries written data
			if (load_fire && dirty != '0) begin
				hold_after_reset <= 1'b0;
			end
			// Clear stays in force until a load after its release
			if (!output_clear_n_i) begin
				hold_clear <= 1'b1;
			end else if (load_fire) begin
				hold_clear <= 1'b0;
			end
		end
	end

	// Buffer connection; grounding never touches stored codes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_connect_o <= 1'b0;
			converter_on_o <= 1'b0;
		end else begin
			converter_on_o <= !(power_down || therm_flag);
			out_connect_o <= dev_reset_n_i && !seq_active && !hold_after_reset && !hold_clear
				&& output_clear_n_i && !power_down && !therm_flag;
		end
	end
endmodule

// file: rtl/duc_params.svh
// Constants for the converter update, clear and busy control block
`ifndef DUC_PARAMS_SVH
`define DUC_PARAMS_SVH

`define DUC_CLK_MHZ 40
`define DUC_STAGE_NS 500
`define DUC_TAIL_NS 250
`define DUC_AB_BUSY_NS 500
`define DUC_RESET_SEQ_US 300
`define DUC_STAGE_CYC ((`DUC_STAGE_NS * `DUC_CLK_MHZ) / 1000)
`define DUC_TAIL_CYC ((`DUC_TAIL_NS * `DUC_CLK_MHZ) / 1000)
`define DUC_AB_BUSY_CYC ((`DUC_AB_BUSY_NS * `DUC_CLK_MHZ) / 1000)
`define DUC_RESET_SEQ_CYC (`DUC_RESET_SEQ_US * `DUC_CLK_MHZ)

`define DUC_ADR_CONTROL 8'h00
`define DUC_ADR_COMMAND 8'h04
`define DUC_ADR_AB_SEL0 8'h08
`define DUC_ADR_STATUS 8'h1c
`define DUC_ADR_CH_INDEX 8'h20
`define DUC_ADR_CH_DATA 8'h24

`define DUC_CTL_POWER_DOWN 0
`define DUC_CTL_THERM_EN 1
`define DUC_CTL_AB_BIT 2
`define DUC_CTL_THERM_FLAG 4

`define DUC_CMD_DATA_LSB 0
`define DUC_CMD_ADDR_LSB 16
`define DUC_CMD_SPAN_LSB 22
`define DUC_CMD_MODE_LSB 24

`define DUC_DEF_INPUT 14'h1555
`define DUC_DEF_GAIN 14'h3fff
`define DUC_DEF_OFFSET 14'h2000
`define DUC_CODE_MID 17'h02000
`define DUC_CODE_MAX 17'h03fff

`endif

// file: rtl/duc_pkg.sv
// Types for the converter update, clear and busy control block
package duc_pkg;
	typedef enum logic [1:0] {
		DUC_MODE_SPECIAL = 2'b00,
		DUC_MODE_GAIN = 2'b01,
		DUC_MODE_OFFSET = 2'b10,
		DUC_MODE_INPUT = 2'b11
	} duc_mode_t;
	typedef enum logic [1:0] {
		DUC_SPAN_ONE = 2'b00,
		DUC_SPAN_GROUP = 2'b01,
		DUC_SPAN_SAME_CH = 2'b10,
		DUC_SPAN_ALL = 2'b11
	} duc_span_t;
	typedef enum logic [1:0] {
		DUC_ENG_IDLE = 2'b00,
		DUC_ENG_CALC = 2'b01,
		DUC_ENG_TAIL = 2'b10
	} duc_eng_t;
endpackage

// file: verification/duc_top_asserts.sv
// Concurrent checks on the ports of the update, clear and busy control block
`timescale 1ns/10ps
module duc_top_chk #(
	parameter int NCH = 40,
	parameter int DW = 14,
	parameter int RESET_SEQ_CYC = 20
) (
	// Clock, reset and bus handshake
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Pins and outputs
	input wire logic dev_reset_n_i,
	input wire logic output_clear_n_i,
	input wire logic busy_n_i,
	input wire logic busy_n_o,
	input wire logic busy_n_oe_o,
	input wire logic [NCH*DW-1:0] out_code_o,
	input wire logic out_connect_o,
	input wire logic converter_on_o
);
	// Longest single write: all channels plus one stage, plus the closing tail
	localparam int BUSY_MAX = 830;
	int busy_cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i || !busy_n_oe_o) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not answered in the next cycle");
	reset_ground_a: assert property (!dev_reset_n_i |=> !out_connect_o)
		else $error("outputs connected during device reset");
	clear_ground_a: assert property (!output_clear_n_i |=> !out_connect_o)
		else $error("outputs connected while clear is low");
	clear_hold_a: assert property ((!output_clear_n_i && dev_reset_n_i) |=> $stable(out_code_o))
		else $error("output registers changed while clear is low");
	busy_hold_a: assert property ((dev_reset_n_i && (!busy_n_i || busy_n_oe_o)) |=> $stable(out_code_o))
		else $error("output registers changed while busy");
	power_ground_a: assert property ($fell(converter_on_o) |-> ##[0:1] !out_connect_o)
		else $error("outputs stay connected after power-down");
	busy_bound_a: assert property (busy_cnt <= BUSY_MAX)
		else $error("busy drive lasts too long");
	busy_low_only_a: assert property (busy_n_oe_o |-> !busy_n_o)
		else $error("busy line driven high");
	cover property (busy_n_oe_o && !busy_n_i);
	cover property ($rose(out_connect_o));
	cover property ($fell(converter_on_o));
endmodule

bind duc_top duc_top_chk #(.NCH(NCH), .DW(DW), .RESET_SEQ_CYC(RESET_SEQ_CYC)) i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.dev_reset_n_i(dev_reset_n_i), .output_clear_n_i(output_clear_n_i), .busy_n_i(busy_n_i),
	.busy_n_o(busy_n_o), .busy_n_oe_o(busy_n_oe_o), .out_code_o(out_code_o),
	.out_connect_o(out_connect_o), .converter_on_o(converter_on_o)
);

// file: verification/duc_peer.sv
// Model of another converter sharing the pulled-up busy wire
`timescale 1ns/10ps
module duc_peer (
	// Clock and hold request
	input wire logic clk_i,
	input wire logic hold_i,
	// Wire
	input wire logic dut_oe_i,
	output logic busy_n_o
);
	logic drive = 1'b0;
	// Peer pulls low while its own work runs
	always_ff @(posedge clk_i) begin
		drive <= hold_i;
	end
	// Released by everyone means the pull-up wins
	assign busy_n_o = (drive || dut_oe_i) ? 1'b0 : 1'b1;
endmodule

// file: verification/duc_top_tb.sv
// Self-checking bench for the update, clear and busy control block
`timescale 1ns/10ps
`include "duc_params.svh"
module duc_top_tb import duc_pkg::*;;
	localparam int SEQ = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_ack_o, busy_n_i, busy_n_o, busy_n_oe_o, out_connect_o, converter_on_o;
	logic dev_reset_n_i = 1'b0, output_clear_n_i = 1'b1, load_strobe_n_i = 1'b1, temp_over_i = 1'b0;
	logic peer_hold = 1'b0;
	logic [40*14-1:0] out_code_o;
	logic [63:0] notes[$];
	logic [63:0] nt;
	logic [13:0] d0, d1;
	int mismatches = 0, checked = 0, n, blen;
	int nch[4] = '{1, 8, 5, 40};
	always #12.5 clk_i = ~clk_i;
	duc_top #(.RESET_SEQ_CYC(SEQ)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_reset_n_i(dev_reset_n_i),
		.output_clear_n_i(output_clear_n_i), .load_strobe_n_i(load_strobe_n_i), .temp_over_i(temp_over_i),
		.busy_n_i(busy_n_i), .busy_n_o(busy_n_o), .busy_n_oe_o(busy_n_oe_o), .out_code_o(out_code_o),
		.out_connect_o(out_connect_o), .converter_on_o(converter_on_o));
	duc_peer i_peer (.clk_i(clk_i), .hold_i(peer_hold), .dut_oe_i(busy_n_oe_o), .busy_n_o(busy_n_i));
	task automatic conclude();
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp_word(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_len(string what, int lo, int hi, int got);
		checked++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
		end
	endtask
	// Reads note their expectation first; a zero mask marks a poll
	task automatic xfer(logic we, logic [7:0] adr, logic [31:0] dat, logic [63:0] note);
		@(posedge clk_i);
		if (!we) notes.push_back(note);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		if (n >= 100) cmp_word("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic wr(logic [7:0] adr, logic [31:0] dat);
		xfer(1'b1, adr, dat, 64'h0);
	endtask
	task automatic rd(logic [7:0] adr, logic [31:0] exp, logic [31:0] mask);
		xfer(1'b0, adr, 32'h0, {mask, exp & mask});
	endtask
	task automatic chan(logic [5:0] ch, logic [13:0] exp);
		wr(`DUC_ADR_CH_INDEX, {26'h0, ch});
		rd(`DUC_ADR_CH_DATA, {18'h0, exp}, 32'h3fff);
		cmp_word("out_code_o", {18'h0, exp}, {18'h0, out_code_o[ch*14 +: 14]});
	endtask
	task automatic cmd(duc_mode_t mode, duc_span_t span, logic [5:0] adr, logic [13:0] dat);
		wr(`DUC_ADR_COMMAND, {6'h0, mode, span, adr, 2'b00, dat});
	endtask
	task automatic wait_idle();
		blen = 0;
		while (busy_n_oe_o === 1'b1 && blen < 2000) begin
			@(posedge clk_i);
			blen++;
		end
		if (blen >= 2000) cmp_word("busy_n_oe_o", 32'h0, {31'h0, busy_n_oe_o});
	endtask
	task automatic pulse();
		@(posedge clk_i);
		load_strobe_n_i <= 1'b0;
		@(posedge clk_i);
		load_strobe_n_i <= 1'b1;
	endtask
	task automatic pins(logic conn, logic on);
		repeat (3) @(posedge clk_i);
		cmp_word("out_connect_o", {31'h0, conn}, {31'h0, out_connect_o});
		cmp_word("converter_on_o", {31'h0, on}, {31'h0, converter_on_o});
	endtask
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i && notes.size() > 0) begin
			nt = notes.pop_front();
			if (nt[63:32] != 32'h0) cmp_word("wb_dat_o", nt[31:0], wb_dat_o & nt[63:32]);
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		conclude();
	end
	initial begin
		void'($urandom(32'h6e9f));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		pins(1'b0, 1'b1);
		dev_reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		wr(`DUC_ADR_CONTROL, 32'h1);
		rdat = 32'h4;
		repeat (60) if (rdat[2] !== 1'b0) rd(`DUC_ADR_STATUS, 32'h0, 32'h0);
		rd(`DUC_ADR_CONTROL, 32'h0, 32'h17);
		pins(1'b0, 1'b1);
		rd(8'h30, 32'h0, 32'hffffffff);
		for (int s = 0; s < 4; s++) begin
			d0 = 14'($urandom());
			cmd(DUC_MODE_INPUT, duc_span_t'(s), 6'h0b, d0);
			wait_idle();
			cmp_len("busy length", nch[s] * `DUC_STAGE_CYC, (nch[s] + 1) * `DUC_STAGE_CYC + `DUC_TAIL_CYC, blen);
			if (s == 0) begin
				pulse();
				chan(6'd11, d0);
				chan(6'd0, 14'h0000);
			end
		end
		pulse();
		pins(1'b1, 1'b1);
		chan(6'd0, d0);
		chan(6'd39, d0);
		output_clear_n_i <= 1'b0;
		d1 = 14'($urandom());
		cmd(DUC_MODE_INPUT, DUC_SPAN_ONE, 6'h05, d1);
		wait_idle();
		pulse();
		pins(1'b0, 1'b1);
		chan(6'd5, d0);
		output_clear_n_i <= 1'b1;
		pins(1'b0, 1'b1);
		pulse();
		pins(1'b1, 1'b1);
		chan(6'd5, d1);
		// Another device keeps the wire low, so the stored load must wait for it
		peer_hold <= 1'b1;
		d0 = 14'($urandom());
		cmd(DUC_MODE_INPUT, DUC_SPAN_ONE, 6'h05, d0);
		pulse();
		wait_idle();
		chan(6'd5, d1);
		rd(`DUC_ADR_STATUS, 32'h8, 32'h8);
		peer_hold <= 1'b0;
		repeat (3) @(posedge clk_i);
		chan(6'd5, d0);
		load_strobe_n_i <= 1'b0;
		repeat (2) begin
			d0 = 14'($urandom());
			cmd(DUC_MODE_INPUT, DUC_SPAN_ONE, 6'h05, d0);
			wait_idle();
			chan(6'd5, d0);
		end
		load_strobe_n_i <= 1'b1;
		wr(`DUC_ADR_CONTROL, 32'h4);
		d1 = 14'($urandom());
		cmd(DUC_MODE_INPUT, DUC_SPAN_ONE, 6'h05, d1);
		wait_idle();
		cmd(DUC_MODE_GAIN, DUC_SPAN_ONE, 6'h05, 14'h1fff);
		wait_idle();
		wr(`DUC_ADR_CONTROL, 32'h0);
		pulse();
		chan(6'd5, d0);
		wr(`DUC_ADR_AB_SEL0, 32'h20);
		wait_idle();
		cmp_len("select busy", 19, 23, blen);
		pulse();
		chan(6'd5, d1 >> 1);
		wr(`DUC_ADR_AB_SEL0, 32'h0);
		wait_idle();
		pulse();
		chan(6'd5, d0);
		wr(`DUC_ADR_CONTROL, 32'h1);
		pins(1'b0, 1'b0);
		chan(6'd5, d0);
		wr(`DUC_ADR_CONTROL, 32'h0);
		pins(1'b1, 1'b1);
		wr(`DUC_ADR_CONTROL, 32'h2);
		temp_over_i <= 1'b1;
		pins(1'b0, 1'b0);
		rd(`DUC_ADR_CONTROL, 32'h12, 32'h12);
		temp_over_i <= 1'b0;
		pins(1'b0, 1'b0);
		wr(`DUC_ADR_CONTROL, 32'h0);
		pins(1'b1, 1'b1);
		// Offset change made under clear; gain of this channel is half scale by now
		output_clear_n_i <= 1'b0;
		cmd(DUC_MODE_OFFSET, DUC_SPAN_ONE, 6'h05, 14'h2010);
		wait_idle();
		pins(1'b0, 1'b1);
		output_clear_n_i <= 1'b1;
		pulse();
		d1 = (d0 >> 1) + 14'h0010;
		chan(6'd5, d1);
		cmd(DUC_MODE_SPECIAL, DUC_SPAN_ALL, 6'h00, 14'h3fff);
		wait_idle();
		pulse();
		chan(6'd5, d1);
		pins(1'b1, 1'b1);
		conclude();
	end
endmodule
